/* File: rtl/csem_core.sv */
// Purpose: core status registers and exception masks
// Assumes: entry, return and special moves come from the pipeline
// Notes: reads answer one cycle after the request
//
// Behaviour
// - field reads 0 in thread, 2 nmi, 3 hard fault; 1 reserved
// - memory fault 4, bus fault 5, usage fault 6; 7..10 reserved
// - supervisor call 11, pendable request 14, tick 15; 12, 13 reserved
// - interrupt lines map to numbers 16 up to 45
// - execution state bit 24 is always 1 in the stacked word
// - direct reads of execution state give zero, writes ignored
// - interrupted multi-transfer records next register in bits 15:12
// - after return the multi-transfer resumes from recorded register
// - continuation held means bits 26:25 and 11:10 are zero
// - conditional block covers at most four following instructions
// - primary mask blocks all configurable-priority exceptions
// - fault mask blocks activation of all exceptions
// - fault mask clears on return from any handler except nmi
// - nonzero threshold blocks priorities greater or equal to it
// - threshold implements bits 7:4, low nibble reads zero
// - stack select 0 main, 1 process; zero and locked in handler
// - control bit 0 set makes thread mode unprivileged
// - entry and return sequencing update the control register
// - after reset thread uses main stack until software selects
// - handler mode while handling any exception except reset
// - data accesses little-endian, byte, halfword, word; doubleword driven as a word, one beat
// - stack select is control bit 1, reset value 0
module csem_core
	import csem_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sr_wr_en,
	input wire logic sr_rd_en,
	input wire logic [7:0] sr_sel,
	input wire logic [31:0] sr_wdata,
	output logic [31:0] sr_rdata,
	output logic sr_rd_valid,
	input wire logic exc_entry,
	input wire logic exc_is_irq,
	input wire logic [4:0] exc_irq_line,
	input wire logic [8:0] exc_entry_num,
	input wire logic exc_return,
	input wire logic [31:0] ret_xpsr,
	input wire logic ret_to_proc_stack,
	output logic exc_entry_refused,
	output logic [31:0] stacked_xpsr,
	output logic [8:0] current_exception_field,
	output logic handler_mode,
	output logic thread_unpriv,
	output logic active_proc_stack,
	input wire logic mt_active,
	input wire logic [3:0] mt_next_reg,
	input wire logic resume_ack,
	output logic resume_valid,
	output logic [3:0] resume_reg,
	input wire logic cb_start,
	input wire logic [3:0] cb_firstcond,
	input wire logic [3:0] cb_mask,
	input wire logic cb_advance,
	output logic [7:0] cb_state,
	input wire logic cand_valid,
	input wire logic [8:0] cand_num,
	input wire logic [7:0] cand_prio,
	output logic cand_allowed,
	output logic cand_blocked,
	input wire logic mem_req,
	input wire logic [1:0] mem_size,
	input wire logic [1:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [3:0] mem_byte_en,
	output logic [31:0] mem_lane_data
);
	logic configurable_priority_mask;
	logic all_exception_mask;
	logic [7:0] priority_threshold_mask;
	csem_mode_t mode;
	logic [8:0] next_entry_num;
	logic entry_legal;
	logic entry_take;
	logic ret_legal;
	logic ret_take;
	logic priv_now;
	logic wr_ok;
	logic rd_ok;
	logic gate_blocked;
	logic [31:0] execution_state_status_stack;
	logic [8:0] ret_num;

	////////////////////////////////////////////////////////////////
	// entry number: interrupt lines count up from the first line
	assign next_entry_num = exc_is_irq ? EXC_IRQ_BASE + {4'h0, exc_irq_line} : exc_entry_num;
	assign entry_legal = exc_is_irq ? exc_irq_line < IRQ_LINES : csem_exc_legal(exc_entry_num);
	assign entry_take = exc_entry && entry_legal;
	assign ret_num = ret_xpsr[8:0];
	assign ret_legal = ret_num == EXC_THREAD || csem_exc_legal(ret_num);
	// entry beats return when both arrive: tail-chained entry wins
	assign ret_take = exc_return && !exc_entry && ret_legal;
	assign priv_now = mode == MODE_HANDLER || !thread_unpriv;
	assign wr_ok = sr_wr_en && priv_now;
	assign rd_ok = sr_rd_en && priv_now;
	assign mode = csem_mode_t'(handler_mode);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			current_exception_field <= EXC_THREAD;
			handler_mode <= MODE_THREAD;
		end else if (entry_take) begin
			current_exception_field <= next_entry_num;
			handler_mode <= MODE_HANDLER;
		end else if (ret_take) begin
			current_exception_field <= ret_num;
			handler_mode <= ret_num != EXC_THREAD;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			exc_entry_refused <= 1'b0;
		end else begin
			// reserved codes never reach the field
			exc_entry_refused <= exc_entry && !entry_legal;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stacked_xpsr <= STATE_RESET;
		end else if (entry_take) begin
			// the only place the true execution state is visible
			stacked_xpsr <= execution_state_status_stack | {23'h00_0000, current_exception_field};
		end
	end

	////////////////////////////////////////////////////////////////
	csem_exec_state u_exec (
		.clk(clk),
		.rst_b(rst_b),
		.entry_take(entry_take),
		.exc_return(ret_take),
		.ret_xpsr(ret_xpsr),
		.mt_active(mt_active),
		.mt_next_reg(mt_next_reg),
		.resume_ack(resume_ack),
		.cb_start(cb_start),
		.cb_firstcond(cb_firstcond),
		.cb_mask(cb_mask),
		.cb_advance(cb_advance),
		.it_state(cb_state),
		.resume_valid(resume_valid),
		.resume_reg(resume_reg),
		.stack_word(execution_state_status_stack)
	);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			configurable_priority_mask <= 1'b0;
		end else if (wr_ok && sr_sel == SEL_PRI_MASK) begin
			configurable_priority_mask <= sr_wdata[MASK_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			all_exception_mask <= 1'b0;
		end else if (wr_ok && sr_sel == SEL_ALL_MASK) begin
			// a software set in the return cycle is kept
			all_exception_mask <= sr_wdata[MASK_BIT];
		end else if (ret_take && current_exception_field != EXC_NMI) begin
			all_exception_mask <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			priority_threshold_mask <= 8'h00;
		end else if (wr_ok && sr_sel == SEL_THRESHOLD) begin
			priority_threshold_mask <= sr_wdata[7:0] & THRESHOLD_IMPL;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			thread_unpriv <= 1'b0;
		end else if (wr_ok && sr_sel == SEL_CONTROL) begin
			thread_unpriv <= sr_wdata[CTRL_PRIV_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			active_proc_stack <= 1'b0;
		end else if (entry_take) begin
			active_proc_stack <= 1'b0;
		end else if (ret_take) begin
			active_proc_stack <= ret_num == EXC_THREAD && ret_to_proc_stack;
		end else if (wr_ok && sr_sel == SEL_CONTROL && mode == MODE_THREAD) begin
			// handler writes to the select bit are dropped
			active_proc_stack <= sr_wdata[CTRL_SPSEL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sr_rdata <= ZERO_WORD;
			sr_rd_valid <= 1'b0;
		end else begin
			sr_rd_valid <= sr_rd_en;
			sr_rdata <= ZERO_WORD;
			// unprivileged reads of these registers give zero
			if (rd_ok) begin
				unique case (sr_sel)
					SEL_PSR, SEL_IEPSR, SEL_EXC_NUM: sr_rdata[8:0] <= current_exception_field;
					SEL_EXEC_STATE: sr_rdata <= ZERO_WORD;
					SEL_PRI_MASK: sr_rdata[MASK_BIT] <= configurable_priority_mask;
					SEL_ALL_MASK: sr_rdata[MASK_BIT] <= all_exception_mask;
					SEL_THRESHOLD: sr_rdata[7:0] <= priority_threshold_mask;
					SEL_CONTROL: begin
						sr_rdata[CTRL_PRIV_BIT] <= thread_unpriv;
						sr_rdata[CTRL_SPSEL_BIT] <= active_proc_stack && mode == MODE_THREAD;
					end
					default: sr_rdata <= ZERO_WORD;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	csem_mask_gate u_gate (
		.pri_mask(configurable_priority_mask),
		.all_mask(all_exception_mask),
		.threshold(priority_threshold_mask),
		.num(cand_num),
		.prio(cand_prio),
		.blocked(gate_blocked)
	);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cand_allowed <= 1'b0;
			cand_blocked <= 1'b0;
		end else begin
			cand_allowed <= cand_valid && !gate_blocked;
			cand_blocked <= cand_valid && gate_blocked;
		end
	end

	////////////////////////////////////////////////////////////////
	// little-endian lanes: lowest address in the lowest byte lane
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mem_byte_en <= 4'h0;
			mem_lane_data <= ZERO_WORD;
		end else if (!mem_req) begin
			mem_byte_en <= 4'h0;
		end else begin
			unique case (csem_size_t'(mem_size))
				SZ_BYTE: begin
					mem_byte_en <= 4'b0001 << mem_addr;
					mem_lane_data <= {4{mem_wdata[7:0]}};
				end
				SZ_HALF: begin
					mem_byte_en <= mem_addr[1] ? 4'b1100 : 4'b0011;
					mem_lane_data <= {2{mem_wdata[15:0]}};
				end
				SZ_WORD, SZ_DWORD: begin
					// doubleword is driven like a word: all four lanes, one beat
					mem_byte_en <= 4'b1111;
					mem_lane_data <= mem_wdata;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_cb_run;
		cb_start && cb_mask != 4'h0 && !entry_take && !exc_return
		##1 (cb_advance && !cb_start && !entry_take && !exc_return) [*4];
	endsequence

	a_exc_field_thread: assert property ($past(!rst_b) |-> current_exception_field == EXC_THREAD)
		else $error("field not thread after reset");
	a_fault_codes: assert property (exc_entry && !exc_is_irq && exc_entry_num inside {9'h001, [9'h007:9'h00a]}
		|=> exc_entry_refused && $stable(current_exception_field))
		else $error("reserved fault code accepted");
	a_sys_codes: assert property (exc_entry && !exc_is_irq && exc_entry_num inside {9'h00c, 9'h00d}
		|=> exc_entry_refused && $stable(current_exception_field))
		else $error("reserved system code accepted");
	a_irq_map: assert property (exc_entry && exc_is_irq && exc_irq_line < IRQ_LINES
		|=> current_exception_field == 9'h010 + {4'h0, $past(exc_irq_line)})
		else $error("interrupt line mapped wrong");
	a_t_bit_stack: assert property (entry_take |=> stacked_xpsr[STATE_T_BIT])
		else $error("stacked state bit not one");
	a_state_read: assert property (sr_rd_en && sr_sel == SEL_EXEC_STATE |=> sr_rd_valid && sr_rdata == ZERO_WORD)
		else $error("execution state read not zero");
	a_cont_record: assert property (entry_take && mt_active |=> stacked_xpsr[15:12] == $past(mt_next_reg))
		else $error("continuation register not recorded");
	a_cont_resume: assert property (ret_take && ret_xpsr[26:25] == 2'b00 && ret_xpsr[11:10] == 2'b00
		&& ret_xpsr[15:12] != 4'h0 |=> resume_valid && resume_reg == $past(ret_xpsr[15:12]))
		else $error("resume register wrong");
	a_cont_zero: assert property (entry_take && mt_active
		|=> stacked_xpsr[26:25] == 2'b00 && stacked_xpsr[11:10] == 2'b00)
		else $error("continuation bits not clean");
	a_cb_length: assert property (s_cb_run |=> cb_state[3:0] == 4'h0)
		else $error("conditional block longer than four");
	a_pri_block: assert property (cand_valid && configurable_priority_mask && cand_num >= EXC_MEMMGT
		|=> cand_blocked && !cand_allowed)
		else $error("primary mask did not block");
	a_all_block: assert property (cand_valid && all_exception_mask |=> cand_blocked && !cand_allowed)
		else $error("fault mask did not block");
	a_fm_exit: assert property (ret_take && current_exception_field != EXC_NMI
		&& !(sr_wr_en && sr_sel == SEL_ALL_MASK) |=> !all_exception_mask)
		else $error("fault mask kept on return");
	a_bp_block: assert property (cand_valid && cand_num >= EXC_MEMMGT && priority_threshold_mask != 8'h00
		&& (cand_prio & THRESHOLD_IMPL) >= priority_threshold_mask |=> cand_blocked)
		else $error("threshold did not block");
	a_bp_low: assert property (priority_threshold_mask[3:0] == 4'h0)
		else $error("threshold low nibble set");
	a_hnd_main_stack: assert property (handler_mode |-> !active_proc_stack)
		else $error("process stack in handler");
	a_priv_wr: assert property (wr_ok && sr_sel == SEL_CONTROL |=> thread_unpriv == $past(sr_wdata[0]))
		else $error("privilege bit not written");
	a_entry_ctrl: assert property (entry_take ##1 ret_take && ret_num == EXC_THREAD && ret_to_proc_stack
		|=> active_proc_stack)
		else $error("return did not restore stack select");
	a_reset_main_stack: assert property ($past(!rst_b) |-> !active_proc_stack && !thread_unpriv)
		else $error("control not cleared by reset");
	a_handler_mode: assert property (handler_mode == (current_exception_field != EXC_THREAD))
		else $error("mode disagrees with field");
	a_byte_lane: assert property (mem_req && mem_size == SZ_BYTE |=> mem_byte_en == 4'b0001 << $past(mem_addr))
		else $error("byte lane not little-endian");
	a_spsel_wr: assert property (wr_ok && sr_sel == SEL_CONTROL && mode == MODE_THREAD && !entry_take
		&& !ret_take |=> active_proc_stack == $past(sr_wdata[1]))
		else $error("stack select not written");
	a_no_mask: assert property (cand_valid && !all_exception_mask && !configurable_priority_mask
		&& priority_threshold_mask == 8'h00 |=> cand_allowed)
		else $error("unmasked exception blocked");
endmodule : csem_core

/* File: inc/csem_pkg.sv */
// Purpose: shared constants for core status and exception masks
// Assumes: special register select codes are local to this core
// Notes: exception numbers sit in a 9-bit field
package csem_pkg;
	localparam int CSEM_NUM_W = 9;
	localparam logic [8:0] EXC_THREAD = 9'h000;
	localparam logic [8:0] EXC_NMI = 9'h002;
	localparam logic [8:0] EXC_HARD = 9'h003;
	localparam logic [8:0] EXC_MEMMGT = 9'h004;
	localparam logic [8:0] EXC_BUS = 9'h005;
	localparam logic [8:0] EXC_USAGE = 9'h006;
	localparam logic [8:0] EXC_SVC = 9'h00b;
	localparam logic [8:0] EXC_PENDSVC = 9'h00e;
	localparam logic [8:0] EXC_TICK = 9'h00f;
	localparam logic [8:0] EXC_IRQ_BASE = 9'h010;
	localparam logic [8:0] EXC_IRQ_LAST = 9'h02d;
	localparam logic [4:0] IRQ_LINES = 5'h1e;
	localparam int STATE_T_BIT = 24;
	localparam int CONT_LSB = 12;
	localparam int IT_HI_LSB = 10;
	localparam int IT_LO_LSB = 25;
	localparam int CTRL_PRIV_BIT = 0;
	localparam int CTRL_SPSEL_BIT = 1;
	localparam int MASK_BIT = 0;
	localparam logic [7:0] THRESHOLD_IMPL = 8'hf0;
	localparam logic [31:0] STATE_RESET = 32'h0100_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	typedef enum logic [7:0] {
		SEL_PSR = 8'h03,
		SEL_IEPSR = 8'h04,
		SEL_EXC_NUM = 8'h05,
		SEL_EXEC_STATE = 8'h06,
		SEL_PRI_MASK = 8'h10,
		SEL_THRESHOLD = 8'h11,
		SEL_ALL_MASK = 8'h13,
		SEL_CONTROL = 8'h14
	} csem_sel_t;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_HALF = 2'b01,
		SZ_WORD = 2'b10,
		SZ_DWORD = 2'b11
	} csem_size_t;
	typedef enum logic {
		MODE_THREAD = 1'b0,
		MODE_HANDLER = 1'b1
	} csem_mode_t;

	function automatic logic csem_exc_legal(input logic [8:0] num);
		csem_exc_legal = (num >= EXC_NMI && num <= EXC_USAGE) || num == EXC_SVC
			|| num == EXC_PENDSVC || num == EXC_TICK
			|| (num >= EXC_IRQ_BASE && num <= EXC_IRQ_LAST);
	endfunction : csem_exc_legal
endpackage : csem_pkg

/* File: rtl/csem_mask_gate.sv */
// Purpose: combined activation gate of the three exception masks
// Assumes: priority values use bits 7:4 only
// Notes: purely combinational, registered by the caller
module csem_mask_gate
	import csem_pkg::*;
(
	input wire logic pri_mask,
	input wire logic all_mask,
	input wire logic [7:0] threshold,
	input wire logic [8:0] num,
	input wire logic [7:0] prio,
	output logic blocked
);
	logic configurable;
	logic below_threshold;

	// reset, nmi and hard fault have fixed priorities
	assign configurable = num >= EXC_MEMMGT;
	assign below_threshold = (threshold & THRESHOLD_IMPL) != 8'h00
		&& (prio & THRESHOLD_IMPL) >= (threshold & THRESHOLD_IMPL);
	assign blocked = all_mask
		|| (configurable && (pri_mask || below_threshold));
endmodule : csem_mask_gate

/* File: rtl/csem_exec_state.sv */
// Purpose: conditional-block and multi-transfer continuation state
// Assumes: pipeline signals one advance per conditional instruction
// Notes: continuation only lives in the stacked word and on resume
module csem_exec_state
	import csem_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic entry_take,
	input wire logic exc_return,
	input wire logic [31:0] ret_xpsr,
	input wire logic mt_active,
	input wire logic [3:0] mt_next_reg,
	input wire logic resume_ack,
	input wire logic cb_start,
	input wire logic [3:0] cb_firstcond,
	input wire logic [3:0] cb_mask,
	input wire logic cb_advance,
	output logic [7:0] it_state,
	output logic resume_valid,
	output logic [3:0] resume_reg,
	output logic [31:0] stack_word
);
	logic ret_is_cont;

	assign ret_is_cont = ret_xpsr[26:25] == 2'b00 && ret_xpsr[11:10] == 2'b00
		&& ret_xpsr[15:12] != 4'h0;
	always_comb begin
		stack_word = STATE_RESET;
		if (mt_active) begin
			stack_word[CONT_LSB +: 4] = mt_next_reg;
		end else begin
			stack_word[IT_HI_LSB +: 6] = it_state[7:2];
			stack_word[IT_LO_LSB +: 2] = it_state[1:0];
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			it_state <= 8'h00;
		end else if (entry_take) begin
			it_state <= 8'h00;
		end else if (exc_return) begin
			it_state <= ret_is_cont ? 8'h00 : {ret_xpsr[15:10], ret_xpsr[26:25]};
		end else if (cb_start && cb_mask != 4'h0) begin
			it_state <= {cb_firstcond, cb_mask};
		end else if (cb_advance) begin
			// mask length caps the block at four instructions
			if (it_state[2:0] == 3'b000) begin
				it_state <= 8'h00;
			end else begin
				it_state[4:0] <= {it_state[3:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			resume_valid <= 1'b0;
			resume_reg <= 4'h0;
		end else if (exc_return && ret_is_cont) begin
			// a new resume wins over an ack in the same cycle
			resume_valid <= 1'b1;
			resume_reg <= ret_xpsr[15:12];
		end else if (resume_ack || entry_take) begin
			resume_valid <= 1'b0;
		end
	end
endmodule : csem_exec_state

/* File: test/csem_pipe_model.sv */
// Purpose: stand-in for pipeline and interrupt controller
// Assumes: each request is held one cycle and taken at the next edge
// Notes: idle inserts gaps before special moves to act as a slow pipeline
module csem_pipe_model
	import csem_pkg::*;
(
	input wire logic clk,
	input wire logic [1:0] idle,
	output logic sr_wr_en,
	output logic sr_rd_en,
	output logic [7:0] sr_sel,
	output logic [31:0] sr_wdata,
	output logic exc_entry,
	output logic exc_is_irq,
	output logic [4:0] exc_irq_line,
	output logic [8:0] exc_entry_num,
	output logic exc_return,
	output logic [31:0] ret_xpsr,
	output logic ret_to_proc_stack,
	output logic cand_valid,
	output logic [8:0] cand_num,
	output logic [7:0] cand_prio
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{sr_wr_en, sr_rd_en, exc_entry, exc_is_irq, exc_return, ret_to_proc_stack, cand_valid} = '0;
		{sr_sel, sr_wdata, exc_irq_line, exc_entry_num, ret_xpsr, cand_num, cand_prio} = '0;
	end
	////////////////////////////////////////
	task automatic sr_move(input logic wr, input logic [7:0] sel, input logic [31:0] d);
		repeat (idle) @(posedge clk);
		@(posedge clk);
		sr_wr_en <= wr;
		sr_rd_en <= !wr;
		sr_sel <= sel;
		sr_wdata <= d;
		@(posedge clk);
		sr_wr_en <= 1'b0;
		sr_rd_en <= 1'b0;
		// released data flips so stale values never look valid
		sr_wdata <= ~d;
		// barrier slot before anything uses the new stack
		if (wr && sel == SEL_CONTROL) @(posedge clk);
	endtask : sr_move
	task automatic entry(input logic irq, input logic [4:0] line, input logic [8:0] num);
		@(posedge clk);
		exc_entry <= 1'b1;
		exc_is_irq <= irq;
		exc_irq_line <= line;
		exc_entry_num <= num;
		@(posedge clk);
		exc_entry <= 1'b0;
	endtask : entry
	task automatic ret(input logic [31:0] x, input logic proc);
		@(posedge clk);
		exc_return <= 1'b1;
		ret_xpsr <= x;
		ret_to_proc_stack <= proc;
		@(posedge clk);
		exc_return <= 1'b0;
		ret_xpsr <= ~x;
	endtask : ret
	task automatic cand(input logic [8:0] n, input logic [7:0] p);
		@(posedge clk);
		cand_valid <= 1'b1;
		cand_num <= n;
		cand_prio <= p;
		@(posedge clk);
		cand_valid <= 1'b0;
	endtask : cand
endmodule : csem_pipe_model

/* File: test/tb_top.sv */
// Purpose: self-checking bench for core status and exception masks
// Assumes: read and gate results come one cycle after the request
// Notes: reads and gate results are matched through queues
module tb_top
	import csem_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, mt_active, resume_ack, cb_start, cb_advance, mem_req;
	logic sr_wr_en, sr_rd_en, exc_entry, exc_is_irq, exc_return, ret_to_proc_stack, cand_valid;
	logic sr_rd_valid, exc_entry_refused, handler_mode, thread_unpriv, active_proc_stack, resume_valid;
	logic cand_allowed, cand_blocked, pm, fm;
	logic [1:0] idle, mem_size, mem_addr;
	logic [3:0] mt_next_reg, resume_reg, cb_firstcond, cb_mask, mem_byte_en, be;
	logic [4:0] exc_irq_line;
	logic [7:0] sr_sel, cand_prio, cb_state, bp, p;
	logic [8:0] exc_entry_num, cand_num, current_exception_field, n;
	logic [31:0] sr_wdata, sr_rdata, ret_xpsr, stacked_xpsr, mem_wdata, mem_lane_data, r;
	logic [31:0] xs_state;
	logic [31:0] rd_q[$];
	logic gate_q[$];
	int cycles, bad_count, tests_run;
	csem_core DUT (.clk, .rst_b, .sr_wr_en, .sr_rd_en, .sr_sel, .sr_wdata, .sr_rdata, .sr_rd_valid,
		.exc_entry, .exc_is_irq, .exc_irq_line, .exc_entry_num, .exc_return, .ret_xpsr, .ret_to_proc_stack,
		.exc_entry_refused, .stacked_xpsr, .current_exception_field, .handler_mode, .thread_unpriv,
		.active_proc_stack, .mt_active, .mt_next_reg, .resume_ack, .resume_valid, .resume_reg, .cb_start,
		.cb_firstcond, .cb_mask, .cb_advance, .cb_state, .cand_valid, .cand_num, .cand_prio,
		.cand_allowed, .cand_blocked, .mem_req, .mem_size, .mem_addr, .mem_wdata, .mem_byte_en,
		.mem_lane_data);
	csem_pipe_model P (.clk, .idle, .sr_wr_en, .sr_rd_en, .sr_sel, .sr_wdata, .exc_entry, .exc_is_irq,
		.exc_irq_line, .exc_entry_num, .exc_return, .ret_xpsr, .ret_to_proc_stack, .cand_valid, .cand_num,
		.cand_prio);
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	function automatic logic [31:0] xs();
		xs_state ^= xs_state << 13;
		xs_state ^= xs_state >> 17;
		xs_state ^= xs_state << 5;
		return xs_state;
	endfunction : xs
	task automatic rd(input logic [7:0] sel, input logic [31:0] exp);
		rd_q.push_back(exp);
		P.sr_move(1'b0, sel, 32'h0000_0000);
	endtask : rd
	task automatic take(input logic [8:0] num);
		logic ok;
		ok = num inside {[2:6], 11, 14, 15, [16:45]};
		P.entry(num >= 16 && num <= 45, num[4:0] - 5'h10, num);
		#1;
		chk({31'h0, exc_entry_refused}, {31'h0, !ok});
		chk({23'h0, current_exception_field}, ok ? {23'h0, num} : 32'h0000_0000);
		chk({31'h0, handler_mode}, {31'h0, ok});
		if (ok) begin
			rd(SEL_EXC_NUM, {23'h0, num});
			P.ret(32'h0100_0000, 1'b0);
		end
	endtask : take
	task automatic cb_go(input logic [3:0] c, input logic [3:0] m, input logic adv);
		@(posedge clk);
		cb_start <= !adv;
		cb_advance <= adv;
		cb_firstcond <= c;
		cb_mask <= m;
		@(posedge clk);
		cb_start <= 1'b0;
		cb_advance <= 1'b0;
		#1;
	endtask : cb_go
	////////////////////////////////////////
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
		if (sr_rd_valid === 1'b1) begin
			chk(sr_rdata, rd_q.pop_front());
		end
		if ((cand_allowed | cand_blocked) === 1'b1) begin
			chk({30'h0, cand_allowed, cand_blocked}, {30'h0, !gate_q[0], gate_q[0]});
			void'(gate_q.pop_front());
		end
	end
	initial begin
		{clk, rst_b, mt_active, resume_ack, cb_start, cb_advance, mem_req, idle, mem_size, mem_addr} = '0;
		{mt_next_reg, cb_firstcond, cb_mask, mem_wdata, cycles, bad_count, tests_run} = '0;
		xs_state = 32'h0000_629a;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(stacked_xpsr, 32'h0100_0000);
		rd(SEL_CONTROL, 32'h0000_0000);
		rd(SEL_EXEC_STATE, 32'h0000_0000);
		P.sr_move(1'b1, SEL_EXEC_STATE, 32'hffff_ffff);
		rd(SEL_IEPSR, 32'h0000_0000);
		foreach (r[i]) take(9'(i));
		take(9'h02d);
		take(9'h02e);
		// conditional state lands in the stacked word only when no continuation
		cb_go(4'h3, 4'h3, 1'b0);
		P.entry(1'b1, 5'h03, 9'h013);
		#1;
		chk(stacked_xpsr & 32'hffff_fe00, 32'h0700_3000);
		chk({24'h0, cb_state}, 32'h0000_0000);
		P.ret(32'h0100_0000, 1'b0);
		cb_go(4'h3, 4'h3, 1'b0);
		mt_active <= 1'b1;
		mt_next_reg <= 4'h5;
		P.entry(1'b1, 5'h03, 9'h013);
		#1;
		chk(stacked_xpsr & 32'hffff_fe00, 32'h0100_5000);
		mt_active <= 1'b0;
		P.ret(32'h0100_5000, 1'b0);
		#1;
		chk({27'h0, resume_valid, resume_reg}, 32'h0000_0015);
		resume_ack <= 1'b1;
		@(posedge clk);
		resume_ack <= 1'b0;
		#1;
		chk({31'h0, resume_valid}, 32'h0000_0000);
		cb_go(4'h0, 4'h1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			cb_go(4'h0, 4'h1, 1'b1);
			chk({31'h0, |cb_state[3:0]}, {31'h0, i < 3});
		end
		// back-to-back advances reach the length check
		@(posedge clk);
		cb_start <= 1'b1;
		cb_mask <= 4'h1;
		@(posedge clk);
		cb_start <= 1'b0;
		cb_advance <= 1'b1;
		repeat (4) @(posedge clk);
		cb_advance <= 1'b0;
		#1;
		chk({24'h0, cb_state}, 32'h0000_0000);
		// fault mask survives only the nmi handler's exit
		P.entry(1'b0, 5'h00, EXC_NMI);
		P.sr_move(1'b1, SEL_ALL_MASK, 32'h0000_0001);
		P.ret(32'h0100_0000, 1'b0);
		rd(SEL_ALL_MASK, 32'h0000_0001);
		P.entry(1'b1, 5'h02, 9'h012);
		P.sr_move(1'b1, SEL_ALL_MASK, 32'h0000_0001);
		P.ret(32'h0100_0000, 1'b0);
		rd(SEL_ALL_MASK, 32'h0000_0000);
		for (int i = 0; i < 40; i++) begin
			r = xs();
			idle = r[5:4];
			pm = r[0];
			fm = r[1] & r[2];
			bp = r[15:8];
			P.sr_move(1'b1, SEL_PRI_MASK, {31'h0, pm});
			P.sr_move(1'b1, SEL_ALL_MASK, {31'h0, fm});
			P.sr_move(1'b1, SEL_THRESHOLD, {24'h0, bp});
			rd(SEL_THRESHOLD, {24'h0, bp & THRESHOLD_IMPL});
			n = {3'b000, r[21:16]} % 9'h02e;
			p = r[31:24];
			gate_q.push_back(fm | (n >= 4 && (pm | (bp[7:4] != 0 && p[7:4] >= bp[7:4]))));
			P.cand(n, p);
		end
		for (int s = 0; s < 4; s++) begin
			r = xs();
			@(posedge clk);
			mem_req <= 1'b1;
			mem_size <= s[1:0];
			mem_addr <= r[1:0];
			mem_wdata <= r;
			@(posedge clk);
			mem_req <= 1'b0;
			#1;
			be = s == 0 ? 4'h1 << r[1:0] : s == 1 ? (r[1] ? 4'hc : 4'h3) : 4'hf;
			chk({28'h0, mem_byte_en}, {28'h0, be});
			chk(mem_lane_data, s == 0 ? {4{r[7:0]}} : s == 1 ? {2{r[15:0]}} : r);
		end
		idle = 2'b00;
		P.sr_move(1'b1, SEL_CONTROL, 32'h0000_0002);
		chk({31'h0, active_proc_stack}, 32'h0000_0001);
		P.entry(1'b1, 5'h00, 9'h010);
		#1;
		chk({31'h0, active_proc_stack}, 32'h0000_0000);
		rd(SEL_CONTROL, 32'h0000_0000);
		P.sr_move(1'b1, SEL_CONTROL, 32'h0000_0002);
		chk({31'h0, active_proc_stack}, 32'h0000_0000);
		P.ret(32'h0100_0000, 1'b1);
		#1;
		chk({31'h0, active_proc_stack}, 32'h0000_0001);
		P.sr_move(1'b1, SEL_CONTROL, 32'h0000_0003);
		chk({31'h0, thread_unpriv}, 32'h0000_0001);
		P.sr_move(1'b1, SEL_PRI_MASK, 32'h0000_0001);
		rd(SEL_PRI_MASK, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk(32'(rd_q.size() + gate_q.size()), 32'h0000_0000);
		complete_run();
	end
endmodule : tb_top
